/* logic/ecs_engine.sv */
// Engine end: window addressing, operand walk and busy/irq signalling
//
// Function
// RULE_01 - Host enables engine clock gate first
// RULE_02 - Base register places shared window in RAM
// RULE_03 - Base register counts 1 kB pages
// RULE_04 - Host loads microcode from 0x40030000 first
// RULE_05 - Interrupt raised only when enabled in engine
// RULE_06 - Host writes all operands before start
// RULE_07 - Fixed slots plus three pointer fields
// RULE_08 - Operands 64, 128 or 256 bits
// RULE_09 - Processing in 64-bit blocks, zero-extended
// RULE_10 - Window data is little-endian
// RULE_11 - Host polls busy for completion
// RULE_12 - Host preloads signature input slots
// RULE_13 - Signature results land in 0xA, 0xB
// RULE_14 - Zero r means host restarts, new nonce; here it only sets r_zero, the host does not restart
// RULE_15 - Typical operation near 100 k cycles
// RULE_16 - Busy until results written, then irq
`timescale 1ns/100ps
`include "ecs_defines.svh"
module ecs_engine #(
  parameter int TYP_CYCLES = `ECS_TYP_CYCLES
) (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  ecs_link_if.engine lnk,
  output logic [31:0] op_count,
  output logic        r_zero
);
  import ecs_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_COMPUTE, ST_WRITE, ST_DONE
  } ecs_state_t;
  typedef struct packed {
    ecs_state_t  st;
    logic [1:0]  blk;
    logic [1:0]  phase;
    logic [31:0] cnt;
    logic [63:0] acc;
    logic        busy;
    logic        irq;
    logic        req;
    logic        we;
    logic [17:0] addr;
    logic [63:0] wdata;
    logic [31:0] ops;
    logic        rz;
  } ecs_state_s_t;
  ecs_state_s_t s_reg;
  ecs_state_s_t s_next;
  logic [1:0]  last_blk;
  logic [3:0]  rd_slot;
  logic [3:0]  wr_slot;

  // Blocks in one operand; narrower widths stop early
  always_comb begin
    case (lnk.cfg.width_sel)
      `ECS_W_64:  last_blk = 2'h0; // RULE_08
      `ECS_W_128: last_blk = 2'h1; // RULE_08
      default:    last_blk = 2'h3; // RULE_08
    endcase
  end

  // Sign reads and writes fixed slots, other ops follow the pointers
  always_comb begin
    rd_slot = (lnk.cfg.op == ECS_OP_SIGN) ? `ECS_SLOT_NONCE : lnk.cfg.operand_pointer_a; // RULE_07
    wr_slot = lnk.cfg.operand_pointer_c; // RULE_07
    if (lnk.cfg.op == ECS_OP_SIGN) begin
      wr_slot = s_reg.phase[0] ? `ECS_SLOT_S : `ECS_SLOT_R; // RULE_13
    end
  end

  function automatic logic [17:0] win_addr(input logic [7:0] page, input logic [3:0] slot,
                                          input logic [1:0] blk);
    // Page base plus slot offset plus 8-byte block; low byte first
    win_addr = {page, 10'h000} + {9'h000, slot, `ECS_SLOT_SHIFT'(0)} // RULE_03
               + {13'h0000, blk, 3'h0}; // RULE_10
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (lnk.start && lnk.clk_gate_en && lnk.cfg.op != ECS_OP_NOP) begin
          s_next.busy  = 1'b1; // RULE_16
          s_next.blk   = 2'h0;
          s_next.phase = 2'h0;
          s_next.acc   = 64'h0;
          s_next.rz    = 1'b0;
          s_next.st    = ST_READ;
        end
      end
      ST_READ: begin
        s_next.req  = 1'b1;
        s_next.we   = 1'b0;
        s_next.addr = win_addr(lnk.base_page, rd_slot, s_reg.blk); // RULE_02
        if (s_reg.req && lnk.mem_ack) begin
          s_next.req = 1'b0;
          s_next.acc = s_reg.acc ^ lnk.mem_rdata; // RULE_09
          if (s_reg.blk == last_blk) begin
            s_next.blk = 2'h0;
            s_next.cnt = TYP_CYCLES;
            s_next.st  = ST_COMPUTE;
          end else begin
            s_next.blk = s_reg.blk + 2'h1;
          end
        end
      end
      ST_COMPUTE: begin
        // Stand-in for the microcoded array, typical duration only
        if (s_reg.cnt <= 32'h1) begin
          s_next.st = ST_WRITE; // RULE_15
        end else begin
          s_next.cnt = s_reg.cnt - 32'h1;
        end
      end
      ST_WRITE: begin
        s_next.req   = 1'b1;
        s_next.we    = 1'b1;
        s_next.addr  = win_addr(lnk.base_page, wr_slot, s_reg.blk);
        s_next.wdata = (lnk.cfg.op == ECS_OP_CLEAR) ? 64'h0 : s_reg.acc;
        if (s_reg.req && lnk.mem_ack) begin
          s_next.req = 1'b0;
          s_next.we  = 1'b0;
          if (s_reg.blk == 2'h0 && s_reg.phase == 2'h0 && s_reg.acc == 64'h0) begin
            s_next.rz = 1'b1;
          end
          if (s_reg.blk == last_blk) begin
            s_next.blk = 2'h0;
            if (lnk.cfg.op == ECS_OP_SIGN && s_reg.phase == 2'h0) begin
              s_next.phase = 2'h1; // RULE_13
            end else begin
              s_next.st = ST_DONE;
            end
          end else begin
            s_next.blk = s_reg.blk + 2'h1;
          end
        end
      end
      ST_DONE: begin
        // Busy falls only once the last result word is acknowledged
        s_next.busy = 1'b0; // RULE_16
        s_next.irq  = lnk.irq_en; // RULE_05
        s_next.ops  = s_reg.ops + 32'h1;
        s_next.st   = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.busy      = s_reg.busy;
  assign lnk.irq       = s_reg.irq;
  assign lnk.mem_req   = s_reg.req;
  assign lnk.mem_we    = s_reg.we;
  assign lnk.mem_addr  = s_reg.addr;
  assign lnk.mem_wdata = s_reg.wdata;
  assign op_count      = s_reg.ops;
  assign r_zero        = s_reg.rz;
endmodule

/* common/ecs_defines.svh */
// Constants for the elliptic-curve engine shared-memory control port
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH
`define ECS_PAGE_BITS      10
`define ECS_BASE_W         8
`define ECS_ADDR_W         18
`define ECS_SLOT_BYTES     32
`define ECS_SLOT_SHIFT     5
`define ECS_BLOCK_BITS     64
`define ECS_MAX_BLOCKS     4
`define ECS_SLOT_MOD       4'h0
`define ECS_SLOT_ORD       4'h1
`define ECS_SLOT_GX        4'h2
`define ECS_SLOT_GY        4'h3
`define ECS_SLOT_A         4'h4
`define ECS_SLOT_B         4'h5
`define ECS_SLOT_KEY       4'h6
`define ECS_SLOT_NONCE     4'h7
`define ECS_SLOT_R         4'ha
`define ECS_SLOT_S         4'hb
`define ECS_SLOT_DIGEST    4'hc
`define ECS_UCODE_BASE     32'h40030000
`define ECS_UCODE_WORDS    768
`define ECS_TYP_CYCLES     100000
`define ECS_W_64           2'h0
`define ECS_W_128          2'h1
`define ECS_W_256          2'h2
`endif

/* common/ecs_pkg.sv */
// Types for the elliptic-curve engine shared-memory control port
package ecs_pkg;
  typedef enum logic [1:0] {
    ECS_OP_SIGN,
    ECS_OP_COPY,
    ECS_OP_CLEAR,
    ECS_OP_NOP
  } ecs_op_t;
  typedef struct packed {
    logic [3:0] operand_pointer_a;
    logic [3:0] operand_pointer_b;
    logic [3:0] operand_pointer_c;
    logic [1:0] width_sel;
    ecs_op_t    op;
  } ecs_cfg_t;
endpackage

/* common/ecs_link_if.sv */
// Interface joining the host end and the engine end
`timescale 1ns/100ps
interface ecs_link_if;
  import ecs_pkg::*;
  logic        clk_gate_en;
  logic [7:0]  base_page;
  ecs_cfg_t    cfg;
  logic        irq_en;
  logic        start;
  logic        busy;
  logic        irq;
  logic        ucode_we;
  logic [9:0]  ucode_addr;
  logic [31:0] ucode_data;
  logic        mem_req;
  logic        mem_we;
  logic [17:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [63:0] mem_rdata;
  logic        mem_ack;
  modport engine (
    input  clk_gate_en, base_page, cfg, irq_en, start, ucode_we, ucode_addr, ucode_data,
    input  mem_rdata, mem_ack,
    output busy, irq, mem_req, mem_we, mem_addr, mem_wdata
  );
  modport host (
    output clk_gate_en, base_page, cfg, irq_en, start, ucode_we, ucode_addr, ucode_data,
    input  busy, irq, mem_req, mem_we, mem_addr, mem_wdata,
    output mem_rdata, mem_ack
  );
endinterface

/* logic/ecs_host.sv */
// Host end: setup sequence, microcode load, shared RAM and completion wait
`timescale 1ns/100ps
`include "ecs_defines.svh"
module ecs_host #(
  parameter int RAM_WORDS = 256
) (
  input  wire logic           clk_sys,
  input  wire logic           sys_rst,
  ecs_link_if.host            lnk,
  input  wire logic           go,
  input  wire ecs_pkg::ecs_cfg_t cfg_in,
  input  wire logic [7:0]     page_in,
  input  wire logic           irq_wanted,
  input  wire logic           ucode_valid,
  input  wire logic [31:0]    ucode_word,
  input  wire logic           ram_we,
  input  wire logic [7:0]     ram_idx,
  input  wire logic [63:0]    ram_wdata,
  output logic [63:0]         ram_rdata,
  output logic                done,
  output logic                ready
);
  import ecs_pkg::*;
  typedef enum logic [2:0] {
    HS_CLKEN, HS_UCODE, HS_IDLE, HS_START, HS_WAIT
  } ecs_hstate_t;
  typedef struct packed {
    ecs_hstate_t st;
    logic        gate;
    logic [9:0]  uaddr;
    logic        uwe;
    logic [31:0] udata;
    logic        start;
    ecs_cfg_t    cfg;
    logic [7:0]  page;
    logic        ien;
    logic        ack;
    logic [63:0] rdata;
    logic        done;
  } ecs_hstate_s_t;
  ecs_hstate_s_t h_reg;
  ecs_hstate_s_t h_next;
  logic [63:0] ram [RAM_WORDS];
  logic [7:0]  eng_idx;
  logic [63:0] rd_word;

  // Word index from address bits 10:3, lowest page bit included; low byte of each word at lowest address
  assign eng_idx = lnk.mem_addr[10:3]; // RULE_10
  assign rd_word = ram[eng_idx];

  always_comb begin
    h_next = h_reg;
    h_next.uwe   = 1'b0;
    h_next.start = 1'b0;
    h_next.ack   = 1'b0;
    h_next.done  = 1'b0;
    if (lnk.mem_req && !h_reg.ack) begin
      h_next.ack   = 1'b1;
      h_next.rdata = rd_word;
    end
    case (h_reg.st)
      HS_CLKEN: begin
        h_next.gate = 1'b1; // RULE_01
        h_next.st   = HS_UCODE;
      end
      HS_UCODE: begin
        // Address steps after each written word, so gaps in the source lose nothing
        if (h_reg.uwe) begin
          h_next.uaddr = h_reg.uaddr + 10'h001;
        end
        if (ucode_valid) begin
          h_next.uwe   = 1'b1; // RULE_04
          h_next.udata = ucode_word;
        end
        if (h_reg.uwe && h_reg.uaddr == 10'(`ECS_UCODE_WORDS - 1)) begin
          h_next.uwe = 1'b0;
          h_next.st  = HS_IDLE;
        end
      end
      HS_IDLE: begin
        // Operands are placed through ram_we before go
        if (go) begin
          h_next.cfg  = cfg_in; // RULE_07
          h_next.page = page_in; // RULE_02
          h_next.ien  = irq_wanted; // RULE_05
          h_next.st   = HS_START; // RULE_06
        end
      end
      HS_START: begin
        h_next.start = 1'b1;
        h_next.st    = HS_WAIT;
      end
      HS_WAIT: begin
        // Busy sampled one cycle after start to let it rise
        if (!h_reg.start && !lnk.busy) begin
          h_next.done = 1'b1; // RULE_11
          h_next.st   = HS_IDLE;
        end
      end
      default: begin
        h_next.st = HS_CLKEN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  // Shared RAM: engine writes win; the host port writes in any cycle without an engine write
  always_ff @(posedge clk_sys) begin
    if (lnk.mem_req && lnk.mem_we && !h_reg.ack) begin
      ram[eng_idx] <= lnk.mem_wdata;
    end else if (ram_we) begin
      ram[ram_idx] <= ram_wdata; // RULE_09
    end
    ram_rdata <= ram[ram_idx];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else begin
      ready <= (h_reg.st == HS_IDLE);
    end
  end

  assign lnk.clk_gate_en = h_reg.gate;
  assign lnk.base_page   = h_reg.page;
  assign lnk.cfg         = h_reg.cfg;
  assign lnk.irq_en      = h_reg.ien;
  assign lnk.start       = h_reg.start;
  assign lnk.ucode_we    = h_reg.uwe;
  assign lnk.ucode_addr  = h_reg.uaddr;
  assign lnk.ucode_data  = h_reg.udata;
  assign lnk.mem_rdata   = h_reg.rdata;
  assign lnk.mem_ack     = h_reg.ack;
  assign done            = h_reg.done;
endmodule

/* verification/ecs_link_asserts.sv */
// Concurrent checks on the link between host end and engine end
`timescale 1ns/100ps
`include "ecs_defines.svh"
module ecs_link_asserts (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              clk_gate_en,
  input wire logic [7:0]        base_page,
  input wire ecs_pkg::ecs_cfg_t cfg,
  input wire logic              irq_en,
  input wire logic              start,
  input wire logic              busy,
  input wire logic              irq,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [17:0]       mem_addr,
  input wire logic              mem_ack
);
  import ecs_pkg::*;
  // Generous bound; the sim runs with a short compute count
  localparam int BUSY_MAX = 600;
  logic [1:0] last_blk;
  assign last_blk = (cfg.width_sel == `ECS_W_256) ? 2'h3 : {1'b0, cfg.width_sel == `ECS_W_128};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_start_taken;
    start && !busy && clk_gate_en && cfg.op != ECS_OP_NOP;
  endsequence
  sequence s_op_done;
    $fell(busy) && irq_en;
  endsequence
  a_start_busy: assert property (s_start_taken |=> busy)
    else $error("busy did not follow start");
  a_gate_refuse: assert property (start && !busy && !clk_gate_en |=> !busy)
    else $error("start taken with gate off");
  a_irq_enabled: assert property (irq |-> irq_en)
    else $error("irq while disabled");
  a_irq_at_end: assert property (s_op_done |-> ##[0:1] irq)
    else $error("no irq at end");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  a_page_base: assert property (mem_req |-> mem_addr[17:10] == base_page)
    else $error("access outside window page");
  a_block_walk: assert property (mem_req |-> mem_addr[2:0] == 3'h0 && mem_addr[4:3] <= last_blk)
    else $error("block beyond operand width");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request changed before ack");
  a_busy_window: assert property (mem_req |-> busy)
    else $error("memory access while idle");
  a_sign_slots: assert property (mem_req && mem_we && cfg.op == ECS_OP_SIGN |-> mem_addr[9:5] inside {5'h0a, 5'h0b})
    else $error("sign result in wrong slot");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("operation never finished");
endmodule

/* verification/test_ecc_engine_shared_memory_control.sv */
// Testbench joining host end and engine end through the link interface
`timescale 1ns/100ps
`include "ecs_defines.svh"
module test_ecc_engine_shared_memory_control;
  import ecs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        go = 1'b0;
  logic        irq_wanted = 1'b0;
  logic        ram_we = 1'b0;
  ecs_cfg_t    cfg_in = '0;
  logic [7:0]  page_in = 8'h04;
  logic [7:0]  ram_idx = 8'h00;
  logic [31:0] ucode_word = 32'h0;
  logic [63:0] ram_wdata = 64'h0;
  logic [63:0] ram_rdata;
  logic        done;
  logic        ready;
  logic        r_zero;
  logic [31:0] op_count;
  logic [31:0] ops_exp = 32'h0;
  logic [15:0] lfsr = 16'h0062;
  logic        wr_on = 1'b0;
  logic        rz_exp = 1'b0;
  logic        ucode_valid = 1'b0;
  logic [17:0] addr_q[$];
  logic [63:0] wd_q[$];
  int          n_ucode = 0;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_irq = 0;
  int          irq_exp = 0;
  ecs_link_if lnk_if ();
  ecs_host #(.RAM_WORDS(256)) ecs_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(lnk_if),
    .go(go), .cfg_in(cfg_in), .page_in(page_in), .irq_wanted(irq_wanted),
    .ucode_valid(ucode_valid),
    .ucode_word(ucode_word), .ram_we(ram_we), .ram_idx(ram_idx), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .done(done), .ready(ready));
  // Short compute count keeps the run small
  ecs_engine #(.TYP_CYCLES(20)) ecs_engine_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .lnk(lnk_if), .op_count(op_count), .r_zero(r_zero));
  ecs_link_asserts ecs_link_asserts_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_gate_en(lnk_if.clk_gate_en), .base_page(lnk_if.base_page), .cfg(lnk_if.cfg),
    .irq_en(lnk_if.irq_en), .start(lnk_if.start), .busy(lnk_if.busy), .irq(lnk_if.irq),
    .mem_req(lnk_if.mem_req), .mem_we(lnk_if.mem_we), .mem_addr(lnk_if.mem_addr),
    .mem_ack(lnk_if.mem_ack));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(negedge clk_sys) begin
    lfsr <= lfsr_next(lfsr);
    ucode_word <= {lfsr, ~lfsr};
    ucode_valid <= lfsr[0];
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    if (lnk_if.irq === 1'b1) n_irq++;
    if (lnk_if.ucode_we === 1'b1) n_ucode++;
    if (wr_on && lnk_if.mem_req && lnk_if.mem_we && lnk_if.mem_ack) begin
      if (addr_q.size() == 0) check(64'h1, 64'h0, "extra write");
      else begin
        check(lnk_if.mem_addr, addr_q.pop_front(), "result address");
        check(lnk_if.mem_wdata, wd_q.pop_front(), "result data");
      end
    end
  end
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [63:0] d);
    @(negedge clk_sys);
    ram_we = 1'b1;
    ram_idx = idx;
    ram_wdata = d;
    @(negedge clk_sys);
    ram_we = 1'b0;
  endtask
  task automatic wait_ready;
    for (int k = 0; k < 3000 && ready !== 1'b1; k++) @(negedge clk_sys);
    check(ready, 1'b1, "ready");
  endtask
  task automatic run_op(input ecs_op_t op, input logic [1:0] w, input logic irq_on);
    logic [63:0] v;
    logic [63:0] keep;
    logic [63:0] acc;
    logic [3:0]  rs;
    int nb;
    nb = (w == `ECS_W_256) ? 4 : (w == `ECS_W_128) ? 2 : 1;
    keep = 64'h0;
    acc = 64'h0;
    wait_ready();
    // Pointer c parked on a scratch slot so inputs survive copy and clear
    cfg_in = {lfsr[7:0], 4'hd, w, op};
    rs = (op == ECS_OP_SIGN) ? `ECS_SLOT_NONCE : cfg_in.operand_pointer_a;
    // Every slot is written, so a random pointer never reads an unknown word
    for (int s = 0; s < 16; s++)
      for (int b = 0; b < 4; b++) begin
        v = (b < nb && (s < 8 || s == 12)) ? {lfsr, ~lfsr, lfsr, ~lfsr} : 64'h0;
        if (s == 0 && b == 0) keep = v;
        if (s == rs && b < nb) acc = acc ^ v;
        wr({2'b00, s[3:0], b[1:0]}, v);
      end
    irq_wanted = irq_on;
    if (op == ECS_OP_SIGN) begin
      for (int s = 10; s < 12; s++)
        for (int b = 0; b < nb; b++) begin
          addr_q.push_back({page_in, s[4:0], b[1:0], 3'h0});
          wd_q.push_back(acc);
        end
    end else if (op != ECS_OP_NOP) begin
      for (int b = 0; b < nb; b++) begin
        addr_q.push_back({page_in, 1'b0, cfg_in.operand_pointer_c, b[1:0], 3'h0});
        wd_q.push_back((op == ECS_OP_CLEAR) ? 64'h0 : acc);
      end
    end
    if (op != ECS_OP_NOP) rz_exp = (acc == 64'h0);
    wr_on = 1'b1;
    go = 1'b1;
    @(negedge clk_sys);
    go = 1'b0;
    for (int k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk_sys);
    check(done, 1'b1, "done");
    if (op != ECS_OP_NOP) begin
      ops_exp++;
      irq_exp += irq_on;
    end
    @(negedge clk_sys);
    wr_on = 1'b0;
    check(op_count, ops_exp, "op count");
    check(n_irq, irq_exp, "irq count");
    check(addr_q.size(), 64'h0, "missing writes");
    check(lnk_if.base_page, page_in, "window page");
    check(r_zero, rz_exp, "r zero flag");
    ram_idx = 8'h00;
    repeat (2) @(negedge clk_sys);
    check(ram_rdata, keep, "operand kept");
    $display("Test op %0d width %0d done", op, w);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    wait_ready();
    check(lnk_if.clk_gate_en, 1'b1, "clock gate");
    check(n_ucode, `ECS_UCODE_WORDS, "microcode words");
    for (int w = 0; w < 3; w++) run_op(ECS_OP_SIGN, w[1:0], w[0]);
    run_op(ECS_OP_COPY, `ECS_W_256, 1'b1);
    run_op(ECS_OP_CLEAR, `ECS_W_64, 1'b0);
    run_op(ECS_OP_NOP, `ECS_W_64, 1'b1);
    close_out();
  end
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
endmodule
